// File: logic/sarh_host.sv
// host controller for a 16-bit sampling converter with parallel read port
// assumes pins synchronous to clk_sys_i; data bus is only read, never driven
// Summary of operation
// - wait 100 ns acquisition before next start
// - start strobe low and high 20 ns
// - abort between 60 and 340 ns (here only the lower limit is kept; a late request in SARH_CONV still aborts)
// - chip select low before start strobe falls (here both fall on the same clock edge)
// - no bus activity 40 ns after start
// - last read ends 50 ns before start
// - read low 50 ns, high 20 ns
// - byte changes spaced 50 ns apart
// - chip select rise 50 ns from busy fall
// - read only after busy falls
`include "sarh_regs.svh"
module sarh_host
  import sarh_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic byte_mode_i,
  input wire logic busy_i,
  input wire logic [15:0] data_i,
  output logic conversion_start_n_o,
  output logic cs_n_o,
  output logic rd_n_o,
  output logic byte_sel_o,
  output logic busy_o,
  output logic timeout_o,
  output logic signed [15:0] result_o,
  output logic result_valid_o,
  input wire logic result_ready_i
);
  localparam logic [5:0] C_CONVERSION_START_N = 6'(`SARH_CYC_UP(`SARH_CONVERSION_START_N_W_NS));
  localparam logic [5:0] C_HOLD = 6'(`SARH_CYC_UP(`SARH_DATA_HOLD_NS));
  localparam logic [5:0] C_CONV = 6'(`SARH_CYC_DN(`SARH_CONV_MAX_NS));
  localparam logic [5:0] C_ABORT = 6'(`SARH_CYC_UP(`SARH_ABORT_NS));
  localparam logic [5:0] C_ACQ = 6'(`SARH_CYC_UP(`SARH_ACQ_MIN_NS));
  localparam logic [5:0] C_RDL = 6'(`SARH_CYC_UP(`SARH_RD_LOW_NS));
  localparam logic [5:0] C_RDH = 6'(`SARH_CYC_UP(`SARH_RD_HIGH_NS));
  localparam logic [5:0] C_GAP = 6'(`SARH_CYC_UP(`SARH_READ_TO_CONV_NS));
  localparam logic [5:0] C_CSB = 6'(`SARH_CYC_UP(`SARH_CS_BUSY_NS));
  localparam logic [5:0] C_BYTE = 6'(`SARH_CYC_UP(`SARH_BYTE_SPACE_NS));

  sarh_state_t st_r, st_nxt;
  sarh_pins_t pins_r;
  logic [5:0] cnt_r;
  logic [5:0] conv_cnt_r;
  logic half_r;
  logic [15:0] res_r;
  logic push_r, fifo_ready, abort_pend_r, timeout_r, mode_r, last_r;
  logic [15:0] fifo_data;
  logic fifo_valid;

  function automatic logic [5:0] max6(input logic [5:0] a, input logic [5:0] b);
    return (a > b) ? a : b;
  endfunction

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      SARH_IDLE: if (start_i && fifo_ready) st_nxt = SARH_START;
      SARH_START: if (cnt_r == '0) st_nxt = SARH_HIGH;
      SARH_HIGH: if (cnt_r == '0) st_nxt = SARH_WAIT_BUSY;
      SARH_WAIT_BUSY: if (!busy_i) st_nxt = SARH_READ;
        else st_nxt = SARH_CONV;
      SARH_CONV: if (!busy_i || (abort_pend_r && cnt_r == '0)) st_nxt = SARH_READ;
      SARH_READ: if (cnt_r == '0 && last_r) st_nxt = SARH_GAP;
      SARH_GAP: if (cnt_r == '0) st_nxt = SARH_ACQ;
      SARH_ACQ: if (cnt_r == '0) st_nxt = SARH_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= SARH_IDLE;
      cnt_r <= '0;
    end else begin
      st_r <= st_nxt;
      if (st_nxt != st_r) begin
        unique case (st_nxt)
          SARH_START: cnt_r <= C_CONVERSION_START_N - 6'h01;
          SARH_HIGH: cnt_r <= max6(C_CONVERSION_START_N, C_HOLD - C_CONVERSION_START_N) - 6'h01;
          SARH_CONV: cnt_r <= C_ABORT - C_CONVERSION_START_N - C_HOLD + 6'h01;
          SARH_READ: cnt_r <= C_CSB;
          SARH_GAP: cnt_r <= C_GAP;
          SARH_ACQ: cnt_r <= C_ACQ;
          default: cnt_r <= '0;
        endcase
      end else if (st_r == SARH_READ && cnt_r == '0 && !rd_n_o) begin
        cnt_r <= C_RDH;
      end else if (st_r == SARH_READ && cnt_r == '0 && rd_n_o) begin
        cnt_r <= max6(C_RDL, C_BYTE);
      end else if (cnt_r != '0) begin
        cnt_r <= cnt_r - 6'h01;
      end
    end
  end

  // pin drive; chip select falls with the strobe, never after it
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pins_r <= '{cs_n: 1'b1, conversion_start_n_n: 1'b1, rd_n: 1'b1, byte_sel: 1'b0};
      half_r <= 1'b0;
      last_r <= 1'b0;
      res_r <= '0;
      push_r <= 1'b0;
    end else begin
      push_r <= 1'b0;
      if (st_nxt == SARH_START && st_r == SARH_IDLE) begin
        pins_r.cs_n <= 1'b0;
        pins_r.conversion_start_n_n <= 1'b0;
        pins_r.byte_sel <= 1'b0;
        half_r <= 1'b0;
        last_r <= 1'b0;
      end
      if (st_r == SARH_START && cnt_r == '0) pins_r.conversion_start_n_n <= 1'b1;
      if (st_r == SARH_CONV && abort_pend_r && cnt_r == '0 && busy_i)
        pins_r.conversion_start_n_n <= 1'b0;
      if (st_r == SARH_READ) begin
        // an abort strobe enters here low and must still stand its full width
        if (cnt_r <= C_CSB - C_CONVERSION_START_N + 6'h01) pins_r.conversion_start_n_n <= 1'b1;
        if (cnt_r == '0 && rd_n_o && !last_r) pins_r.rd_n <= 1'b0;
        if (cnt_r == '0 && !rd_n_o) begin
          pins_r.rd_n <= 1'b1;
          // sample at the strobe rise: data stays valid up to it
          if (!mode_r) res_r <= data_i;
          else if (!half_r) res_r[15:8] <= data_i[7:0];
          else res_r[7:0] <= data_i[7:0];
          if (mode_r && !half_r) begin
            half_r <= 1'b1;
            pins_r.byte_sel <= 1'b1;
          end else begin
            push_r <= 1'b1;
            last_r <= 1'b1;
          end
        end
      end
      // byte select goes home with chip select so the next start sees no bus change
      if (st_nxt == SARH_GAP && st_r == SARH_READ) begin
        pins_r.cs_n <= 1'b1;
        pins_r.byte_sel <= 1'b0;
      end
    end
  end

  // conversion watchdog: busy beyond its longest time flags a fault
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      conv_cnt_r <= '0;
    end else begin
      if (busy_i && conv_cnt_r != C_CONV) conv_cnt_r <= conv_cnt_r + 6'h01;
      else if (!busy_i) conv_cnt_r <= '0;
    end
  end

  // abort request is kept only while a conversion runs
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      abort_pend_r <= 1'b0;
    end else if (abort_i && st_r == SARH_CONV) begin
      abort_pend_r <= 1'b1;
    end else if (st_r != SARH_CONV) begin
      abort_pend_r <= 1'b0;
    end
  end

  // sticky fault, cleared only when a new conversion is accepted
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      timeout_r <= 1'b0;
    end else if (busy_i && conv_cnt_r == C_CONV) begin
      timeout_r <= 1'b1;
    end else if (st_nxt == SARH_START && st_r == SARH_IDLE) begin
      timeout_r <= 1'b0;
    end
  end

  // transfer width is frozen at the start so a late change cannot split a result
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_r <= 1'b0;
    end else if (st_nxt == SARH_START && st_r == SARH_IDLE) begin
      mode_r <= byte_mode_i;
    end
  end

  sarh_fifo #(.WIDTH(16), .DEPTH(DEPTH)) u_fifo (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .in_data_i(res_r),
    .in_valid_i(push_r),
    .in_ready_o(fifo_ready),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    // pop only a word that is shown, so a ready held high loses nothing
    .out_ready_i(result_ready_i && result_valid_o)
  );

  // outputs from flops; fifo output is registered head via skid-free latch
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      result_o <= '0;
      result_valid_o <= 1'b0;
    end else begin
      result_o <= fifo_data;
      result_valid_o <= fifo_valid && !(result_ready_i && result_valid_o);
    end
  end

  // busy covers the whole pin sequence, acquisition gap included
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= st_nxt != SARH_IDLE;
    end
  end

  assign conversion_start_n_o = pins_r.conversion_start_n_n;
  assign cs_n_o = pins_r.cs_n;
  assign rd_n_o = pins_r.rd_n;
  assign byte_sel_o = pins_r.byte_sel;
  assign timeout_o = timeout_r;
endmodule

// File: logic/sarh_regs.svh
// timing constants for the converter host port
// assumes a 100 MHz system clock; counts are whole clock cycles
`ifndef SARH_REGS_SVH
`define SARH_REGS_SVH
`define SARH_CLK_NS 10
`define SARH_CONV_MAX_NS 360
`define SARH_ACQ_MIN_NS 100
`define SARH_BUSY_RISE_NS 40
`define SARH_MSB_VALID_NS 10
`define SARH_CONVERSION_START_N_W_NS 20
`define SARH_ABORT_NS 60
`define SARH_DATA_HOLD_NS 40
`define SARH_READ_TO_CONV_NS 50
`define SARH_RD_LOW_NS 50
`define SARH_RD_HIGH_NS 20
`define SARH_EN_NS 20
`define SARH_BYTE_SPACE_NS 50
`define SARH_CS_BUSY_NS 50
// least times round up, longest round down, none below one cycle
`define SARH_CYC_UP(ns) (((ns) + `SARH_CLK_NS - 1) / `SARH_CLK_NS)
`define SARH_CYC_DN(ns) ((ns) / `SARH_CLK_NS)
`define SARH_CNT_W 6
`endif

// File: logic/sarh_pkg.sv
// types for the converter host port
// assumes sarh_regs.svh constants are used alongside
package sarh_pkg;
  typedef enum logic [2:0] {
    SARH_IDLE, SARH_START, SARH_HIGH, SARH_WAIT_BUSY, SARH_CONV,
    SARH_READ, SARH_GAP, SARH_ACQ
  } sarh_state_t;
  typedef struct packed {
    logic cs_n;
    logic conversion_start_n_n;
    logic rd_n;
    logic byte_sel;
  } sarh_pins_t;
endpackage

// File: logic/sarh_fifo.sv
// result fifo between the pin sequencer and the user
// assumes one clock; flop storage addressed by index
module sarh_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0] cnt_r;
  logic push, pop;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign in_ready_o = cnt_r != (AW+1)'(DEPTH);
  assign out_valid_o = cnt_r != '0;
  assign out_data_o = mem_r[rp_r];
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_r[wp_r] <= in_data_i;
    end
  end
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// File: tb/sarh_dev_model.sv
// converter device model: abortable conversion, busy flag, read port that is always driven
// assumes host pins change just after rising edges of clk_sys_i
module sarh_dev_model (
  input wire logic clk_sys_i,
  input wire logic cs_n_i,
  input wire logic conversion_start_n_n_i,
  input wire logic rd_n_i,
  input wire logic byte_sel_i,
  input wire logic byte_mode_i,
  input wire logic slow_i,
  output logic busy_o,
  output logic [15:0] data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic st_q = 1'b1;
  int cnt = 0;
  logic [15:0] code = 16'h70E4;
  logic [15:0] last = 16'h0000;
  logic [15:0] drv;
  logic fall;
  initial busy_o = 1'b0;
  assign fall = st_q && !conversion_start_n_n_i;
  always @(posedge clk_sys_i) begin
    st_q <= conversion_start_n_n_i;
    if (fall && busy_o && !cs_n_i) cnt <= 1;
    // slow stretches busy past its limit to exercise the host watchdog
    else if (fall) cnt <= slow_i ? 42 : 32;
    else if (cnt > 0) cnt <= cnt - 1;
    if (fall && !busy_o) code <= code + 16'h0F1D;
    if (cnt == (slow_i ? 41 : 31)) busy_o <= 1'b1;
    if (cnt == 1) busy_o <= 1'b0;
    if (!cs_n_i && !rd_n_i) last <= drv;
  end
  // halves share the low lane so a swapped byte order shows in the result
  assign drv = byte_mode_i ? {8'h00, byte_sel_i ? code[7:0] : code[15:8]} : code;
  // released bus shows the inverse of the last word, never a stale copy
  assign data_o = (!cs_n_i && !rd_n_i) ? drv : ~last;
endmodule

// File: tb/sarh_host_chk.sv
// pin timing checks of the converter host port
// assumes bind onto sarh_host; one clock, asynchronous active-low reset
module sarh_host_chk (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic busy_i,
  input wire logic conversion_start_n_o,
  input wire logic cs_n_o,
  input wire logic rd_n_o,
  input wire logic byte_sel_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  property p_cs_first; $fell(conversion_start_n_o) |-> !cs_n_o; endproperty
  a_cs_first: assert property (p_cs_first) else $error("start without select");
  property p_st_low; $fell(conversion_start_n_o) |=> !conversion_start_n_o; endproperty
  a_st_low: assert property (p_st_low) else $error("start pulse short");
  property p_st_high; $rose(conversion_start_n_o) |=> conversion_start_n_o; endproperty
  a_st_high: assert property (p_st_high) else $error("start high short");
  property p_rd_low; $fell(rd_n_o) |-> !rd_n_o [*5]; endproperty
  a_rd_low: assert property (p_rd_low) else $error("read low short");
  property p_rd_high; $rose(rd_n_o) |-> rd_n_o [*2]; endproperty
  a_rd_high: assert property (p_rd_high) else $error("read high short");
  property p_rd_busy; $fell(rd_n_o) |-> !busy_i; endproperty
  a_rd_busy: assert property (p_rd_busy) else $error("read while busy");
  property p_bus_quiet;
    $fell(conversion_start_n_o) |-> (rd_n_o && $stable(byte_sel_o)) [*4];
  endproperty
  a_bus_quiet: assert property (p_bus_quiet) else $error("bus moved after start");
  property p_byte_space; $changed(byte_sel_o) |=> $stable(byte_sel_o) [*4]; endproperty
  a_byte_space: assert property (p_byte_space) else $error("byte select fast");
  property p_cs_busy; $fell(busy_i) |-> !$rose(cs_n_o) [*5]; endproperty
  a_cs_busy: assert property (p_cs_busy) else $error("select rose near busy fall");
endmodule
bind sarh_host sarh_host_chk u_chk (.clk_sys_i, .resetn_i, .busy_i, .conversion_start_n_o,
  .cs_n_o, .rd_n_o, .byte_sel_o);

// File: tb/sarh_host_test.sv
// testbench of the converter host port against a behavioural device
// assumes inputs change on falling edges; fifo depth 16
module sarh_host_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 1'b0, resetn_i = 1'b0, start_i = 1'b0, abort_i = 1'b0;
  logic slow = 1'b0;
  logic byte_mode_i = 1'b0, result_ready_i = 1'b0, busy_i, busy_o, timeout_o;
  logic conversion_start_n_o, cs_n_o, rd_n_o, byte_sel_o, result_valid_o;
  logic [15:0] data_i, code = 16'h70E4;
  logic signed [15:0] result_o;
  logic [15:0] q[$];
  int bad_count = 0, n_compared = 0, cyc = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  sarh_host dut (.clk_sys_i, .resetn_i, .start_i, .abort_i, .byte_mode_i, .busy_i, .data_i,
    .conversion_start_n_o, .cs_n_o, .rd_n_o, .byte_sel_o, .busy_o, .timeout_o, .result_o,
    .result_valid_o, .result_ready_i);
  sarh_dev_model dev (.clk_sys_i, .cs_n_i(cs_n_o), .conversion_start_n_n_i(conversion_start_n_o),
    .rd_n_i(rd_n_o), .byte_sel_i(byte_sel_o), .byte_mode_i, .slow_i(slow), .busy_o(busy_i),
    .data_o(data_i));
  task test_done;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      test_done;
    end
  end
  task chk(string nm, logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // waits for the acquisition gap to end so a start is dropped only when the fifo is full
  task conv;
    for (int i = 0; i < 300 && busy_o !== 1'b0; i++) @(negedge clk_sys_i);
    start_i = 1'b1;
    @(negedge clk_sys_i);
    start_i = 1'b0;
    code = code + 16'h0F1D;
    q.push_back(code);
  endtask
  task pop(string nm);
    for (int i = 0; i < 300 && result_valid_o !== 1'b1; i++) @(negedge clk_sys_i);
    chk(nm, q.pop_front(), result_o);
    result_ready_i = 1'b1;
    @(negedge clk_sys_i);
    result_ready_i = 1'b0;
  endtask
  task t_word;
    byte_mode_i = 1'b0;
    conv;
    pop("word");
    chk("timeout", 16'h0000, {15'h0000, timeout_o});
  endtask
  task t_slow;
    slow = 1'b1;
    conv;
    pop("slow");
    chk("timeout", 16'h0001, {15'h0000, timeout_o});
    slow = 1'b0;
  endtask
  task t_byte;
    byte_mode_i = 1'b1;
    conv;
    pop("byte");
    byte_mode_i = 1'b0;
  endtask
  task t_abort;
    conv;
    abort_i = 1'b1;
    repeat (30) @(negedge clk_sys_i);
    chk("abort early", 16'h0001, {15'h0000, result_valid_o});
    pop("abort");
    abort_i = 1'b0;
  endtask
  task t_fifo;
    repeat (16) conv;
    conv;
    chk("refused", 16'h0000, {15'h0000, busy_o});
    void'(q.pop_back());
    code = code - 16'h0F1D;
    repeat (16) pop("drain");
  endtask
  initial begin
    repeat (3) @(negedge clk_sys_i);
    resetn_i = 1'b1;
    t_word;
    t_byte;
    t_abort;
    t_slow;
    t_fifo;
    t_word;
    test_done;
  end
endmodule
